//--- design/vgr_general_regs.sv
// general registers, palette ports and sequencer index of a vga core
// What this block does
// R1: page-select bit picks odd (0) or even (1) locations in even/odd mode
// R2: page select ignored when graphics chain or chain-four is set
// R3: external clock enable high: clock select picks one of four sources
// R4: enable low: dot clock pin feeds dac, plus crt counters if bit 3 set
// R5: memory enable bit 1 clear makes display memory accesses ignored
// R6: decode bit moves status/crt ports between 3Bx and 3Dx
// R7: feature bit 3 ORs display enable into vertical sync output
// R8: status zero bit 7 shows pending interrupt, bit 4 dac sense
// R9: status one bits 5:4 show attribute pair picked by plane enable
// R10: status one bit 3 shows vertical retrace
// R11: status one bit 0 is 1 during blanking, 0 while displaying
// R12: pixel ANDed with pixel mask before palette lookup
// R13: read index increments after every third data read
// R14: third data write commits the entry then increments write index
// R15: host loads an index then moves red, green, blue triplets
// R16: dac state reads 00 after write-index load, 11 after read-index
// R17: pixel mask address also reaches the hidden dac register
// R18: 5-bit sequencer index selects register behind the data port
// R19: sequencer indices above five go to extension registers
// R20: sync polarity bits: 0 idles low pulses high, 1 inverted
// R21: either sequencer reset bit clear halts the sequencer
// R22: reserved bits read zero and ignore writes
module vgr_general_regs
  import vgr_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // host i/o port bus
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_claim,
  // extension and crt port access
  output logic o_ext_seq_sel,
  output logic o_crt_idx_sel,
  output logic o_crt_dat_sel,
  output logic o_hidden_dac_sel,
  input wire logic [7:0] i_ext_rdata,
  // sequencer memory mode and graphics chain
  input wire logic i_odd_even_addressing_bit,
  input wire logic i_chain_four_bit,
  input wire logic i_graphics_chain_bit,
  input wire logic i_cpu_addr_lsb,
  input wire logic i_mem_req,
  output logic o_mem_ack_en,
  output logic o_mem_lsb_force,
  output logic o_mem_lsb,
  // clocks
  input wire logic i_external_clock_enable,
  output logic [1:0] o_video_clock_sel,
  output logic o_use_external_dot_clock_pin,
  output logic o_dot_clk_to_crt,
  // timing status
  input wire logic i_hsync_raw,
  input wire logic i_vsync_raw,
  input wire logic i_display_en,
  input wire logic i_vretrace,
  input wire logic i_blanking,
  input wire logic i_irq_pending,
  input wire logic i_dac_sense,
  input wire logic [7:0] i_attr_out,
  input wire logic [1:0] i_colour_plane_enable,
  output logic o_hsync,
  output logic o_vsync,
  output logic o_seq_run,
  // pixel path
  input wire logic [7:0] i_pixel,
  output logic [17:0] o_pixel_rgb
);
  // ***********************************************************
  // state
  // ***********************************************************
  logic [7:0] misc_q, misc_d;
  logic [7:0] fc_q, fc_d;
  logic [7:0] sr0_q, sr0_d;
  logic [4:0] sidx_q, sidx_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] ridx_q, ridx_d;
  logic [7:0] widx_q, widx_d;
  logic [1:0] dstate_q, dstate_d;
  vgr_comp_t rcnt_q, rcnt_d, wcnt_q, wcnt_d;
  logic [5:0] wred_q, wgrn_q;
  logic [7:0] rdata_q;
  logic claim_q;
  logic hs_q, vs_q, run_q, ack_q, force_q, lsb_q;
  logic [1:0] vsel_q;
  logic ext_q, crtclk_q, eseq_q, crti_q, crtd_q, hdac_q;
  logic [17:0] rgb_q;
  logic [7:0] pix_q;
  logic [5:0] t_sync;
  logic [7:0] dbg_sync;
  vgr_lut_if lut();

  // pin-facing status except dac sense passes the three-stage synchroniser
  vgr_sync3 #(.W(6)) u_tsync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_async({i_hsync_raw, i_vsync_raw, i_display_en, i_vretrace,
              i_blanking, i_irq_pending}),
    .o_sync(t_sync)
  );
  vgr_sync3 #(.W(8)) u_async (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_async(i_attr_out),
    .o_sync(dbg_sync)
  );
  wire hs_s = t_sync[5];
  wire vs_s = t_sync[4];
  wire de_s = t_sync[3];
  wire vr_s = t_sync[2];
  wire bl_s = t_sync[1];
  wire irq_s = t_sync[0];

  vgr_lut_mem u_lut (
    .i_ref_clk(i_ref_clk),
    .lut(lut)
  );

  // ***********************************************************
  // address decode
  // ***********************************************************
  wire col = misc_q[VGR_MISC_IOCOL];
  wire [15:0] a_stat = col ? VGR_STAT_COLR : VGR_STAT_MONO; // see R6
  wire [15:0] a_crx = col ? VGR_CRX_COLR : VGR_CRX_MONO; // see R6
  wire [15:0] a_crd = col ? VGR_CRD_COLR : VGR_CRD_MONO; // see R6
  wire hit_misc_w = i_io_addr == VGR_MISC_WR;
  wire hit_misc_r = i_io_addr == VGR_MISC_RD;
  wire hit_stat = i_io_addr == a_stat;
  wire hit_fc_r = i_io_addr == VGR_FC_RD;
  wire hit_sidx = i_io_addr == VGR_SEQ_IDX;
  wire hit_sdat = i_io_addr == VGR_SEQ_DAT;
  wire hit_mask = i_io_addr == VGR_PIX_MASK;
  wire hit_ridx = i_io_addr == VGR_RD_IDX;
  wire hit_widx = i_io_addr == VGR_WR_IDX;
  wire hit_data = i_io_addr == VGR_PIX_DATA;
  wire hit_crx = i_io_addr == a_crx;
  wire hit_crd = i_io_addr == a_crd;
  wire seq_ext = sidx_q > VGR_SEQ_STD_MAX; // see R19
  wire seq_sr0 = sidx_q == VGR_SR0_IDX; // see R18
  wire seq_std = !seq_ext && !seq_sr0;
  wire any_hit = hit_misc_w | hit_misc_r | hit_stat | hit_fc_r | hit_sidx
               | hit_sdat | hit_mask | hit_ridx | hit_widx | hit_data
               | hit_crx | hit_crd;
  wire wr = i_io_wr;
  wire rd = i_io_rd && !i_io_wr;
  wire data_rd = rd && hit_data;
  wire data_wr = wr && hit_data;

  // ***********************************************************
  // register writes
  // ***********************************************************
  // reserved bits are masked off on write
  assign misc_d = (wr && hit_misc_w) ? (i_io_wdata & VGR_MISC_WMASK)
                : misc_q; // see R22
  assign fc_d = (wr && hit_stat) ? (i_io_wdata & VGR_FC_WMASK)
              : fc_q; // see R22
  assign sr0_d = (wr && hit_sdat && seq_sr0)
               ? (i_io_wdata & VGR_SR0_WMASK) : sr0_q; // see R21
  assign sidx_d = (wr && hit_sidx) ? i_io_wdata[VGR_SEQ_IDX_W-1:0]
                : sidx_q; // see R18
  assign mask_d = (wr && hit_mask) ? i_io_wdata : mask_q;

  // palette counters: index load restarts the triplet
  wire rcnt_end = data_rd && rcnt_q == VGR_BLUE;
  wire wcnt_end = data_wr && wcnt_q == VGR_BLUE;
  assign ridx_d = (wr && hit_ridx) ? i_io_wdata
                : rcnt_end ? ridx_q + 8'h01 : ridx_q; // see R13
  assign widx_d = (wr && hit_widx) ? i_io_wdata
                : wcnt_end ? widx_q + 8'h01 : widx_q; // see R14
  assign rcnt_d = (wr && hit_ridx) ? VGR_RED
                : !data_rd ? rcnt_q
                : rcnt_q == VGR_BLUE ? VGR_RED
                : vgr_comp_t'(rcnt_q + 2'h1); // see R13
  assign wcnt_d = (wr && hit_widx) ? VGR_RED
                : !data_wr ? wcnt_q
                : wcnt_q == VGR_BLUE ? VGR_RED
                : vgr_comp_t'(wcnt_q + 2'h1); // see R14
  assign dstate_d = (wr && hit_widx) ? VGR_DSTATE_WR
                  : (wr && hit_ridx) ? VGR_DSTATE_RD : dstate_q; // see R16

  // lookup memory hookup
  assign lut.we = wcnt_end; // see R14
  assign lut.waddr = widx_q;
  assign lut.wdata = {wred_q, wgrn_q, i_io_wdata[5:0]};
  assign lut.raddr = ridx_d;
  assign lut.paddr = pix_q;

  // ***********************************************************
  // read data mux
  // ***********************************************************
  wire [7:0] isr0 = {irq_s, 2'b00, i_dac_sense, 4'h0}; // see R8
  wire [1:0] diag =
      (i_colour_plane_enable == 2'b00) ? {dbg_sync[2], dbg_sync[0]}
    : (i_colour_plane_enable == 2'b01) ? {dbg_sync[5], dbg_sync[4]}
    : (i_colour_plane_enable == 2'b10) ? {dbg_sync[3], dbg_sync[1]}
    : {dbg_sync[7], dbg_sync[6]}; // see R9
  wire [7:0] isr1 = {2'b00, diag, vr_s, 2'b00, bl_s}; // see R10 see R11
  wire [5:0] rcomp = (rcnt_q == VGR_RED) ? lut.rdata[17:12]
                   : (rcnt_q == VGR_GREEN) ? lut.rdata[11:6]
                   : lut.rdata[5:0]; // see R13
  wire [7:0] rmux =
      hit_misc_w ? isr0
    : hit_misc_r ? misc_q
    : hit_fc_r ? fc_q
    : hit_stat ? isr1
    : hit_sidx ? {3'b000, sidx_q}
    : (hit_sdat && seq_sr0) ? sr0_q
    : hit_sdat ? i_ext_rdata
    : hit_mask ? mask_q
    : hit_ridx ? {6'h00, dstate_q}
    : hit_widx ? widx_q
    : hit_data ? {2'b00, rcomp}
    : hit_crx | hit_crd ? i_ext_rdata
    : 8'h00;

  // ***********************************************************
  // datapath and output decode
  // ***********************************************************
  wire page_ok = i_odd_even_addressing_bit && !i_graphics_chain_bit
               && !i_chain_four_bit; // see R2
  wire page = misc_q[VGR_MISC_PAGE];
  wire vs_or = fc_q[VGR_FC_VSCTL] ? (vs_s | de_s) : vs_s; // see R7

  // register bank and all outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      misc_q <= VGR_MISC_RST;
      fc_q <= VGR_FC_RST;
      sr0_q <= VGR_SR0_RST;
      sidx_q <= '0;
      mask_q <= VGR_MASK_RST;
      ridx_q <= '0;
      widx_q <= '0;
      dstate_q <= VGR_DSTATE_WR;
      rcnt_q <= VGR_RED;
      wcnt_q <= VGR_RED;
      wred_q <= '0;
      wgrn_q <= '0;
      rdata_q <= '0;
      claim_q <= 1'b0;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      run_q <= 1'b1;
      ack_q <= 1'b0;
      force_q <= 1'b0;
      lsb_q <= 1'b0;
      vsel_q <= '0;
      ext_q <= 1'b0;
      crtclk_q <= 1'b0;
      eseq_q <= 1'b0;
      crti_q <= 1'b0;
      crtd_q <= 1'b0;
      hdac_q <= 1'b0;
      rgb_q <= '0;
      pix_q <= '0;
    end else begin
      misc_q <= misc_d;
      fc_q <= fc_d;
      sr0_q <= sr0_d;
      sidx_q <= sidx_d;
      mask_q <= mask_d;
      ridx_q <= ridx_d;
      widx_q <= widx_d;
      dstate_q <= dstate_d;
      rcnt_q <= rcnt_d;
      wcnt_q <= wcnt_d;
      if (data_wr && wcnt_q == VGR_RED) begin
        wred_q <= i_io_wdata[5:0];
      end
      if (data_wr && wcnt_q == VGR_GREEN) begin
        wgrn_q <= i_io_wdata[5:0];
      end
      rdata_q <= rd ? rmux : 8'h00;
      claim_q <= (rd | wr) && any_hit;
      hs_q <= hs_s ^ misc_q[VGR_MISC_HPOL]; // see R20
      vs_q <= vs_or ^ misc_q[VGR_MISC_VPOL]; // see R20
      run_q <= &sr0_q[1:0]; // see R21
      ack_q <= i_mem_req && misc_q[VGR_MISC_MEMEN]; // see R5
      force_q <= page_ok; // see R1
      lsb_q <= page_ok ? !page : i_cpu_addr_lsb; // see R1
      vsel_q <= misc_q[VGR_MISC_CLK_HI:VGR_MISC_CLK_LO]; // see R3
      ext_q <= !i_external_clock_enable; // see R4
      crtclk_q <= !i_external_clock_enable
                  && misc_q[VGR_MISC_CLK_HI]; // see R4
      // select only pulses on a data port access, never on the index alone
      eseq_q <= (rd | wr) && hit_sdat
                && (seq_std | seq_ext); // see R19
      crti_q <= (rd | wr) && hit_crx;
      crtd_q <= (rd | wr) && hit_crd;
      hdac_q <= (rd | wr) && hit_mask; // see R17
      pix_q <= i_pixel & mask_q; // see R12
      rgb_q <= lut.pdata;
    end
  end

  assign o_io_rdata = rdata_q;
  assign o_io_claim = claim_q;
  assign o_ext_seq_sel = eseq_q;
  assign o_crt_idx_sel = crti_q;
  assign o_crt_dat_sel = crtd_q;
  assign o_hidden_dac_sel = hdac_q;
  assign o_mem_ack_en = ack_q;
  assign o_mem_lsb_force = force_q;
  assign o_mem_lsb = lsb_q;
  assign o_video_clock_sel = vsel_q;
  assign o_use_external_dot_clock_pin = ext_q;
  assign o_dot_clk_to_crt = crtclk_q;
  assign o_hsync = hs_q;
  assign o_vsync = vs_q;
  assign o_seq_run = run_q;
  assign o_pixel_rgb = rgb_q;
endmodule

//--- design/vgr_lut_if.sv
// interface: palette lookup memory ports
interface vgr_lut_if;
  logic we;
  logic [7:0] waddr;
  logic [17:0] wdata;
  logic [7:0] raddr;
  logic [17:0] rdata;
  logic [7:0] paddr;
  logic [17:0] pdata;
  modport ctl (output we, waddr, wdata, raddr, paddr,
               input rdata, pdata);
  modport mem (input we, waddr, wdata, raddr, paddr,
               output rdata, pdata);
endinterface

//--- design/vgr_lut_mem.sv
// palette lookup memory: 256 entries of red, green, blue
module vgr_lut_mem
  import vgr_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // memory ports
  vgr_lut_if.mem lut
);
  logic [17:0] mem_q [256];
  logic [17:0] rdata_q;
  logic [17:0] pdata_q;

  // write port and two registered read ports
  always_ff @(posedge i_ref_clk) begin
    if (lut.we) begin
      mem_q[lut.waddr] <= lut.wdata;
    end
    rdata_q <= mem_q[lut.raddr];
    pdata_q <= mem_q[lut.paddr];
  end

  assign lut.rdata = rdata_q;
  assign lut.pdata = pdata_q;
endmodule

//--- design/vgr_pkg.sv
// package: port addresses, field positions and reset values
package vgr_pkg;
  // ***********************************************************
  // i/o port addresses
  // ***********************************************************
  localparam logic [15:0] VGR_MISC_WR = 16'h03C2;
  localparam logic [15:0] VGR_MISC_RD = 16'h03CC;
  localparam logic [15:0] VGR_FC_RD = 16'h03CA;
  localparam logic [15:0] VGR_STAT_MONO = 16'h03BA;
  localparam logic [15:0] VGR_STAT_COLR = 16'h03DA;
  localparam logic [15:0] VGR_CRX_MONO = 16'h03B4;
  localparam logic [15:0] VGR_CRX_COLR = 16'h03D4;
  localparam logic [15:0] VGR_CRD_MONO = 16'h03B5;
  localparam logic [15:0] VGR_CRD_COLR = 16'h03D5;
  localparam logic [15:0] VGR_SEQ_IDX = 16'h03C4;
  localparam logic [15:0] VGR_SEQ_DAT = 16'h03C5;
  localparam logic [15:0] VGR_PIX_MASK = 16'h03C6;
  localparam logic [15:0] VGR_RD_IDX = 16'h03C7;
  localparam logic [15:0] VGR_WR_IDX = 16'h03C8;
  localparam logic [15:0] VGR_PIX_DATA = 16'h03C9;
  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int VGR_MISC_VPOL = 7;
  localparam int VGR_MISC_HPOL = 6;
  localparam int VGR_MISC_PAGE = 5;
  localparam int VGR_MISC_CLK_HI = 3;
  localparam int VGR_MISC_CLK_LO = 2;
  localparam int VGR_MISC_MEMEN = 1;
  localparam int VGR_MISC_IOCOL = 0;
  localparam int VGR_FC_VSCTL = 3;
  localparam int VGR_SEQ_IDX_W = 5;
  localparam logic [4:0] VGR_SEQ_STD_MAX = 5'h05;
  localparam logic [4:0] VGR_SR0_IDX = 5'h00;
  // ***********************************************************
  // write masks and reset values
  // ***********************************************************
  localparam logic [7:0] VGR_MISC_WMASK = 8'hEF;
  localparam logic [7:0] VGR_FC_WMASK = 8'h08;
  localparam logic [7:0] VGR_SR0_WMASK = 8'h03;
  localparam logic [7:0] VGR_MISC_RST = 8'h00;
  localparam logic [7:0] VGR_FC_RST = 8'h00;
  localparam logic [7:0] VGR_SR0_RST = 8'h03;
  localparam logic [7:0] VGR_MASK_RST = 8'hFF;
  localparam logic [1:0] VGR_DSTATE_WR = 2'h0;
  localparam logic [1:0] VGR_DSTATE_RD = 2'h3;
  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [1:0] {VGR_RED, VGR_GREEN, VGR_BLUE} vgr_comp_t;
endpackage

//--- design/vgr_sync3.sv
// three-stage pin synchroniser with agreement check
module vgr_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // pin side
  input wire logic [W-1:0] i_async,
  // synchronous side
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  // bit changes once stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    s1_q <= i_async;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (i_reset) begin
      out_q <= '0;
    end else begin
      out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
    end
  end

  assign o_sync = out_q;
endmodule

//--- tb/test_vgr_general_regs.sv
// testbench: registers, status, palette and sequencer ports
module test_vgr_general_regs
  import vgr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0, i_reset = 1'b1;
  logic [15:0] i_io_addr;
  logic i_io_wr, i_io_rd, o_io_claim, o_ext_seq_sel, o_crt_idx_sel;
  logic [7:0] i_io_wdata, o_io_rdata, i_ext_rdata = 8'h5A;
  logic [7:0] i_attr_out = 8'h4D, i_pixel = 8'hFF;
  logic o_crt_dat_sel, o_hidden_dac_sel, o_mem_ack_en, o_mem_lsb_force;
  logic o_mem_lsb, o_use_external_dot_clock_pin, o_dot_clk_to_crt;
  logic i_odd_even_addressing_bit = 1'b0, i_chain_four_bit = 1'b0;
  logic i_graphics_chain_bit = 1'b0, i_cpu_addr_lsb = 1'b1;
  logic i_mem_req = 1'b0, i_external_clock_enable = 1'b1;
  logic i_hsync_raw = 1'b0, i_vsync_raw = 1'b0, i_display_en = 1'b0;
  logic i_vretrace = 1'b0, i_blanking = 1'b0, i_irq_pending = 1'b0;
  logic i_dac_sense = 1'b0, o_hsync, o_vsync, o_seq_run;
  logic [1:0] o_video_clock_sel, i_colour_plane_enable = 2'h0;
  logic [1:0] prs [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
  logic [17:0] o_pixel_rgb;
  int n_errors = 0, num_checks = 0;
  // 40 MHz reference clock
  always #12.5 i_ref_clk = ~i_ref_clk;
  vgr_host_model vgr_host_model_i (.i_ref_clk, .o_io_addr(i_io_addr),
    .o_io_wr(i_io_wr), .o_io_rd(i_io_rd), .o_io_wdata(i_io_wdata),
    .i_io_rdata(o_io_rdata));
  vgr_general_regs vgr_general_regs_i (.i_ref_clk, .i_reset, .i_io_addr,
    .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata, .o_io_claim,
    .o_ext_seq_sel, .o_crt_idx_sel, .o_crt_dat_sel, .o_hidden_dac_sel,
    .i_ext_rdata, .i_odd_even_addressing_bit, .i_chain_four_bit,
    .i_graphics_chain_bit, .i_cpu_addr_lsb, .i_mem_req, .o_mem_ack_en,
    .o_mem_lsb_force, .o_mem_lsb, .i_external_clock_enable,
    .o_video_clock_sel, .o_use_external_dot_clock_pin, .o_dot_clk_to_crt,
    .i_hsync_raw, .i_vsync_raw, .i_display_en, .i_vretrace, .i_blanking,
    .i_irq_pending, .i_dac_sense, .i_attr_out, .i_colour_plane_enable,
    .o_hsync, .o_vsync, .o_seq_run, .i_pixel, .o_pixel_rgb);
  // compare and count
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    vgr_host_model_i.wr(a, d);
  endtask
  // read one port and compare
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    vgr_host_model_i.rd(a, d);
    check(d, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog: the tests need well under 1000 cycles
  initial begin
    #(25 * 4000);
    n_errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_reset = 1'b0;
    rdc(VGR_MISC_RD, 8'h00);
    rdc(VGR_PIX_MASK, 8'hFF);
    rdc(VGR_RD_IDX, 8'h00);
    rdc(16'h0100, 8'h00);
    $display("test reset done");
    wr(VGR_MISC_WR, 8'hFF);
    rdc(VGR_MISC_RD, 8'hEF);
    check(o_video_clock_sel, 2'h3);
    i_external_clock_enable = 1'b0;
    idle(2);
    check({o_use_external_dot_clock_pin, o_dot_clk_to_crt}, 2'h3);
    wr(VGR_MISC_WR, 8'hF7);
    i_mem_req = 1'b1;
    i_odd_even_addressing_bit = 1'b1;
    idle(8);
    check({o_use_external_dot_clock_pin, o_dot_clk_to_crt}, 2'h2);
    check(o_mem_ack_en, 1'b1);
    check({o_mem_lsb_force, o_mem_lsb}, 2'h2);
    check({o_hsync, o_vsync}, 2'h3);
    i_chain_four_bit = 1'b1;
    idle(2);
    check({o_mem_lsb_force, o_mem_lsb}, 2'h1);
    i_chain_four_bit = 1'b0;
    i_graphics_chain_bit = 1'b1;
    idle(2);
    check({o_mem_lsb_force, o_mem_lsb}, 2'h1);
    i_graphics_chain_bit = 1'b0;
    wr(VGR_MISC_WR, 8'h01);
    idle(2);
    check({o_mem_ack_en, o_mem_lsb_force, o_mem_lsb}, 3'h3);
    check({o_hsync, o_vsync}, 2'h0);
    wr(VGR_STAT_COLR, 8'hFF);
    wr(VGR_STAT_MONO, 8'h00);
    rdc(VGR_FC_RD, 8'h08);
    i_display_en = 1'b1;
    idle(8);
    check(o_vsync, 1'b1);
    $display("test misc done");
    i_irq_pending = 1'b1;
    i_dac_sense = 1'b1;
    i_vretrace = 1'b1;
    i_blanking = 1'b1;
    idle(8);
    rdc(VGR_MISC_WR, 8'h90);
    for (int k = 0; k < 4; k++) begin
      i_colour_plane_enable = 2'(k);
      rdc(VGR_STAT_COLR, {2'h0, prs[k], 4'h9});
    end
    rdc(VGR_STAT_MONO, 8'h00);
    rdc(VGR_CRX_COLR, 8'h5A);
    check({o_crt_idx_sel, o_crt_dat_sel, o_io_claim}, 3'h5);
    rdc(VGR_CRD_MONO, 8'h00);
    check({o_crt_dat_sel, o_io_claim}, 2'h0);
    i_vretrace = 1'b0;
    i_blanking = 1'b0;
    idle(8);
    rdc(VGR_STAT_COLR, 8'h10);
    $display("test status done");
    wr(VGR_WR_IDX, 8'hFF);
    wr(VGR_PIX_DATA, 8'h3F);
    wr(VGR_PIX_DATA, 8'h15);
    wr(VGR_PIX_DATA, 8'h2A);
    wr(VGR_PIX_DATA, 8'h01);
    wr(VGR_PIX_DATA, 8'h02);
    wr(VGR_PIX_DATA, 8'h03);
    rdc(VGR_WR_IDX, 8'h01);
    wr(VGR_RD_IDX, 8'hFF);
    rdc(VGR_RD_IDX, 8'h03);
    rdc(VGR_PIX_DATA, 8'h3F);
    rdc(VGR_PIX_DATA, 8'h15);
    rdc(VGR_PIX_DATA, 8'h2A);
    rdc(VGR_PIX_DATA, 8'h01);
    check(o_pixel_rgb, {6'h3F, 6'h15, 6'h2A});
    wr(VGR_PIX_MASK, 8'h00);
    idle(3);
    check(o_pixel_rgb, {6'h01, 6'h02, 6'h03});
    $display("test palette done");
    wr(VGR_SEQ_IDX, 8'hFF);
    rdc(VGR_SEQ_IDX, 8'h1F);
    wr(VGR_SEQ_IDX, 8'h06);
    check(o_ext_seq_sel, 1'b0);
    rdc(VGR_SEQ_DAT, 8'h5A);
    check({o_ext_seq_sel, o_io_claim}, 2'h3);
    wr(VGR_SEQ_IDX, 8'h00);
    wr(VGR_SEQ_DAT, 8'hFE);
    rdc(VGR_SEQ_DAT, 8'h02);
    check(o_seq_run, 1'b0);
    wr(VGR_SEQ_DAT, 8'h03);
    idle(1);
    check(o_seq_run, 1'b1);
    i_reset = 1'b1;
    idle(2);
    i_reset = 1'b0;
    rdc(VGR_PIX_MASK, 8'hFF);
    check(o_hidden_dac_sel, 1'b1);
    $display("test sequencer done");
    give_verdict();
  end
endmodule
bind vgr_general_regs vgr_general_regs_sva vgr_general_regs_sva_i (
  .i_ref_clk, .i_reset, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata,
  .o_io_rdata, .o_io_claim, .o_ext_seq_sel, .o_crt_idx_sel,
  .o_hidden_dac_sel, .i_mem_req, .o_mem_ack_en, .i_external_clock_enable,
  .o_use_external_dot_clock_pin, .o_dot_clk_to_crt, .o_seq_run);

//--- tb/vgr_general_regs_sva.sv
// checker: port timing of the general register block
module vgr_general_regs_sva
  import vgr_pkg::*;
(
  // clock, reset and host bus
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_claim,
  // selects and status
  input wire logic o_ext_seq_sel,
  input wire logic o_crt_idx_sel,
  input wire logic o_hidden_dac_sel,
  input wire logic i_mem_req,
  input wire logic o_mem_ack_en,
  input wire logic i_external_clock_enable,
  input wire logic o_use_external_dot_clock_pin,
  input wire logic o_dot_clk_to_crt,
  input wire logic o_seq_run
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  // any host access this cycle
  wire acc = i_io_wr | i_io_rd;
  // sequencer index loads and data port access
  sequence s_idx0;
    i_io_wr && i_io_addr == VGR_SEQ_IDX && i_io_wdata[4:0] == VGR_SR0_IDX;
  endsequence
  sequence s_idx_ext;
    i_io_wr && i_io_addr == VGR_SEQ_IDX
      && i_io_wdata[4:0] > VGR_SEQ_STD_MAX;
  endsequence
  sequence s_dat;
    acc && i_io_addr == VGR_SEQ_DAT;
  endsequence
  AST_EXT_SEQ:
    assert property (s_idx_ext ##2 s_dat |=> o_ext_seq_sel)
    else $error("extension select missing");
  AST_STD_SEQ:
    assert property (s_idx0 ##2 s_dat |=> !o_ext_seq_sel)
    else $error("standard index routed to extension");
  AST_SEQ_HALT:
    assert property (s_idx0 ##2 (s_dat and (i_io_wr
      && i_io_wdata[1:0] != 2'h3)) |-> ##[1:2] !o_seq_run)
    else $error("sequencer not halted");
  AST_EXT_ONLY:
    assert property (o_ext_seq_sel
      |-> $past(acc) && $past(i_io_addr) == VGR_SEQ_DAT)
    else $error("extension select without data port access");
  AST_DAC_SEL:
    assert property (acc && i_io_addr == VGR_PIX_MASK |=> o_hidden_dac_sel)
    else $error("hidden dac select missing");
  AST_UNMAPPED:
    assert property (acc && i_io_addr[15:8] != 8'h03
      |=> !o_io_claim && o_io_rdata == 8'h00)
    else $error("unmapped port answered");
  AST_CRT_IDX:
    assert property (acc && i_io_addr != VGR_CRX_MONO
      && i_io_addr != VGR_CRX_COLR |=> !o_crt_idx_sel)
    else $error("crt index select on wrong port");
  AST_INT_CLK:
    assert property (i_external_clock_enable
      |=> !o_use_external_dot_clock_pin)
    else $error("dot clock pin used with internal clock");
  AST_CRT_CLK:
    assert property (o_dot_clk_to_crt |-> o_use_external_dot_clock_pin)
    else $error("crt fed from pin while internal clock");
  AST_MEM_ACK:
    assert property (o_mem_ack_en |-> $past(i_mem_req))
    else $error("memory ack without request");
  AST_CLAIM:
    assert property (acc && i_io_addr == VGR_PIX_DATA |=> o_io_claim)
    else $error("data port access not claimed");
endmodule

//--- tb/vgr_host_model.sv
// host model: one-cycle i/o read and write strobes
module vgr_host_model (
  // clock
  input wire logic i_ref_clk,
  // i/o bus to the device
  output logic [15:0] o_io_addr,
  output logic o_io_wr,
  output logic o_io_rd,
  output logic [7:0] o_io_wdata,
  input wire logic [7:0] i_io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial begin
    o_io_addr = 16'h0000;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_wdata = 8'h00;
  end
  // write strobe held over one rising edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_io_addr = a;
    o_io_wdata = d;
    o_io_wr = 1'b1;
    @(negedge i_ref_clk);
    o_io_wr = 1'b0;
    o_io_addr = ~a; // released bus never keeps a stale value
    o_io_wdata = ~d;
  endtask
  // read strobe; data taken in the answer cycle
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    o_io_addr = a;
    o_io_rd = 1'b1;
    @(negedge i_ref_clk);
    d = i_io_rdata;
    o_io_rd = 1'b0;
    o_io_addr = ~a;
  endtask
endmodule
